//--- dcp_defines.vh
// Purpose: constants for the deserializer csi/test-pattern control register group
// Assumes: register offsets are word indices; the apb byte address is four times the index
// Notes: definitions only
`ifndef DCP_DEFINES_VH
`define DCP_DEFINES_VH
// ==========================================================
// register indices (byte address = index * 4)
`define DCP_IDX_TP_IADDR 8'h66
`define DCP_IDX_TP_IDATA 8'h67
`define DCP_IDX_TP_CTRL 8'h68
`define DCP_IDX_TP_RESULT 8'h69
`define DCP_IDX_CSI_CFGA 8'h6A
`define DCP_IDX_CSI_CFGB 8'h6B
`define DCP_IDX_TX_IADDR 8'h6C
`define DCP_IDX_TX_IDATA 8'h6D
`define DCP_IDX_PIN_LOW 8'h6E
`define DCP_IDX_PIN_HIGH 8'h6F
`define DCP_IDX_ID_FIRST 8'hF0
`define DCP_IDX_ID_SECOND 8'hF1
// ==========================================================
// field positions
`define DCP_BIT_SELFTEST_EN 3
`define DCP_BIT_SELFTEST_ERR 7
`define DCP_BIT_DATA_LP 3
`define DCP_BIT_CLK_LP 2
`define DCP_BIT_CONT_CLK 1
`define DCP_BIT_TX_DIS 0
`define DCP_BIT_VS_INV 1
`define DCP_BIT_DE_INV 0
`define DCP_BIT_TIMING_SEL 2
// ==========================================================
// reset values and indirect locations
`define DCP_RST_BYTE 8'h00
`define DCP_TP_ERRCNT_LOC 8'hFF
`define DCP_TP_TIMING_LOC 8'hFE
`define DCP_LANES_FOUR 3'h4
`define DCP_LANES_TWO 3'h2
`define DCP_LANES_ONE 3'h1
// arbitrary neutral identity values
`define DCP_ID_FIRST_VAL 8'hA1
`define DCP_ID_SECOND_VAL 8'hB2
`endif

//--- dcp_ctrl_regs.v
// Purpose: apb register group for test-pattern self-test and csi-2 output control
// Assumes: pin and video inputs are synchronous to clk
// Notes: indirect spaces are small local arrays; generator and csi core sit outside
// Operation
// - pattern data port reaches addressed location
// - self-test enable compares received against generated
// - error flag set when error count nonzero
// - lane code selects four, two, one lanes
// - data low-power bit sends lanes to LP00
// - clock low-power only with data low-power
// - continuous clock keeps clock lane high-speed
// - disable bit holds csi machine in reset
// - four-bit field selects output format
// - two-bit field declares input format
// - vsync invert before csi logic
// - csi logic uses active-high sync and enable
// - enable invert before csi logic
// - tx indirect address register selects location
// - tx indirect data port reads and writes
// - read-only live pin level status; pin 4 reads as zero
// - read-only fixed identity bytes
// - timing select picks internal or external timing
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "dcp_defines.vh"
module dcp_ctrl_regs (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [9:0] pinLevel,
    input wire rxVsync,
    input wire rxDataEnable,
    input wire rxPixel,
    input wire [23:0] rxVideo,
    input wire [23:0] genVideo,
    output reg vsyncActive,
    output reg dataEnableActive,
    output reg selftestRun,
    output reg selftestError,
    output reg internalTiming,
    output reg [2:0] laneCount,
    output reg dataLaneLowPower,
    output reg clockLaneLowPower,
    output reg continuousClock,
    output reg csiSoftReset,
    output reg [3:0] outputFormat,
    output reg [1:0] inputFormat
);
// ==========================================================
// registers
reg [7:0] tpAddr_r;
reg [7:0] tpCtrl_r;
reg [7:0] cfgA_r;
reg [7:0] cfgB_r;
reg [7:0] txAddr_r;
reg [7:0] tpMem [0:255];
reg [7:0] txMem [0:255];
reg [7:0] errCount_r;
reg [7:0] rdByte;
wire [9:0] regIdx;
wire wrEn;
wire rdEn;
wire hit;
wire ack;
integer i;

assign regIdx = paddr[11:2];
assign ack = psel && penable && !pready;
assign wrEn = ack && pwrite;
assign rdEn = ack && !pwrite;
assign hit = (paddr[1:0] == 2'h0) && (regIdx[9:8] == 2'h0) &&
    ((regIdx[7:0] >= `DCP_IDX_TP_IADDR && regIdx[7:0] <= `DCP_IDX_PIN_HIGH) ||
     regIdx[7:0] == `DCP_IDX_ID_FIRST || regIdx[7:0] == `DCP_IDX_ID_SECOND);

// ==========================================================
// read mux
always @*
begin
    rdByte = `DCP_RST_BYTE;
    case (regIdx[7:0])
        `DCP_IDX_TP_IADDR: rdByte = tpAddr_r;
        `DCP_IDX_TP_IDATA: rdByte = (tpAddr_r == `DCP_TP_ERRCNT_LOC) ? errCount_r :
            tpMem[tpAddr_r];
        `DCP_IDX_TP_CTRL: rdByte = tpCtrl_r;
        `DCP_IDX_TP_RESULT: rdByte = {selftestError, 7'h00};
        `DCP_IDX_CSI_CFGA: rdByte = cfgA_r;
        `DCP_IDX_CSI_CFGB: rdByte = cfgB_r;
        `DCP_IDX_TX_IADDR: rdByte = txAddr_r;
        `DCP_IDX_TX_IDATA: rdByte = txMem[txAddr_r];
        `DCP_IDX_PIN_LOW: rdByte = {pinLevel[7:5], 1'b0, pinLevel[3:0]};
        `DCP_IDX_PIN_HIGH: rdByte = {6'h00, pinLevel[9:8]};
        `DCP_IDX_ID_FIRST: rdByte = `DCP_ID_FIRST_VAL;
        `DCP_IDX_ID_SECOND: rdByte = `DCP_ID_SECOND_VAL;
        default: rdByte = `DCP_RST_BYTE;
    endcase
end

// ==========================================================
// apb slave: one wait state, answer one cycle after access phase starts
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        pready <= ack;
        pslverr <= ack && !hit;
        if (rdEn)
            prdata <= hit ? {24'h000000, rdByte} : 32'h00000000;
    end
end

// ==========================================================
// configuration writes
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        tpAddr_r <= `DCP_RST_BYTE;
        tpCtrl_r <= `DCP_RST_BYTE;
        cfgA_r <= `DCP_RST_BYTE;
        cfgB_r <= `DCP_RST_BYTE;
        txAddr_r <= `DCP_RST_BYTE;
    end
    else if (wrEn && hit)
    begin
        case (regIdx[7:0])
            `DCP_IDX_TP_IADDR: tpAddr_r <= pwdata[7:0];
            `DCP_IDX_TP_CTRL: tpCtrl_r <= pwdata[7:0];
            `DCP_IDX_CSI_CFGA: cfgA_r <= pwdata[7:0];
            `DCP_IDX_CSI_CFGB: cfgB_r <= pwdata[7:0];
            `DCP_IDX_TX_IADDR: txAddr_r <= pwdata[7:0];
            default: tpAddr_r <= tpAddr_r;
        endcase
    end
end

// ==========================================================
// indirect arrays: cleared on reset so a readback is never unknown
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        for (i = 0; i < 256; i = i + 1)
        begin
            tpMem[i] <= `DCP_RST_BYTE;
            txMem[i] <= `DCP_RST_BYTE;
        end
    end
    else
    begin
        if (wrEn && hit && regIdx == {2'h0, `DCP_IDX_TP_IDATA} &&
            tpAddr_r != `DCP_TP_ERRCNT_LOC)
            tpMem[tpAddr_r] <= pwdata[7:0];
        if (wrEn && hit && regIdx == {2'h0, `DCP_IDX_TX_IDATA})
            txMem[txAddr_r] <= pwdata[7:0];
    end
end

// ==========================================================
// self-test compare; counter saturates so the flag cannot wrap back to zero
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        errCount_r <= 8'h00;
    else if (!tpCtrl_r[`DCP_BIT_SELFTEST_EN])
        errCount_r <= 8'h00;
    else if (rxPixel && dataEnableActive && rxVideo != genVideo && errCount_r != 8'hFF)
        errCount_r <= errCount_r + 8'h01;
end

// ==========================================================
// outputs to generator and csi core
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        vsyncActive <= 1'b0;
        dataEnableActive <= 1'b0;
        selftestRun <= 1'b0;
        selftestError <= 1'b0;
        internalTiming <= 1'b0;
        laneCount <= `DCP_LANES_FOUR;
        dataLaneLowPower <= 1'b0;
        clockLaneLowPower <= 1'b0;
        continuousClock <= 1'b0;
        csiSoftReset <= 1'b0;
        outputFormat <= 4'h0;
        inputFormat <= 2'h0;
    end
    else
    begin
        vsyncActive <= rxVsync ^ cfgB_r[`DCP_BIT_VS_INV];
        dataEnableActive <= rxDataEnable ^ cfgB_r[`DCP_BIT_DE_INV];
        selftestRun <= tpCtrl_r[`DCP_BIT_SELFTEST_EN];
        selftestError <= tpCtrl_r[`DCP_BIT_SELFTEST_EN] && (errCount_r != 8'h00);
        internalTiming <= tpMem[`DCP_TP_TIMING_LOC][`DCP_BIT_TIMING_SEL];
        case (cfgA_r[5:4])
            2'h2: laneCount <= `DCP_LANES_TWO;
            2'h3: laneCount <= `DCP_LANES_ONE;
            default: laneCount <= `DCP_LANES_FOUR;
        endcase
        dataLaneLowPower <= cfgA_r[`DCP_BIT_DATA_LP];
        clockLaneLowPower <= cfgA_r[`DCP_BIT_DATA_LP] && cfgA_r[`DCP_BIT_CLK_LP];
        continuousClock <= cfgA_r[`DCP_BIT_CONT_CLK];
        csiSoftReset <= cfgA_r[`DCP_BIT_TX_DIS];
        outputFormat <= cfgB_r[7:4];
        inputFormat <= cfgB_r[3:2];
    end
end

endmodule // dcp_ctrl_regs

//--- dcp_ctrl_regs_monitor.sv
// Purpose: port checks for dcp_ctrl_regs
// Assumes: byte address is index times four
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`include "dcp_defines.vh"
module dcp_ctrl_regs_monitor (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire [9:0] pinLevel,
    input wire selftestRun,
    input wire selftestError,
    input wire [2:0] laneCount,
    input wire dataLaneLowPower,
    input wire clockLaneLowPower,
    input wire csiSoftReset
);
    // ==========
    // checks
    wire take = psel && penable && !pready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ready_next: assert property (take |=> pready ##1 !pready)
        else $error("answer not one cycle after access");
    a_lane_code: assert property (laneCount inside {3'h4, 3'h2, 3'h1})
        else $error("lane count out of set");
    a_clock_lp_dep: assert property (clockLaneLowPower |-> dataLaneLowPower)
        else $error("clock lane low power alone");
    a_err_needs_run: assert property (selftestError |-> selftestRun || $past(selftestRun))
        else $error("error flag without self-test");
    a_err_clear: assert property ($fell(selftestRun) |-> ##[0:2] !selftestError)
        else $error("error flag stuck after disable");
    // late copy allowed: checked two edges after the write lands
    a_cfg_write: assert property (take && pwrite && paddr == 12'h1A8 |=> ##1
        csiSoftReset == $past(pwdata[0], 2) && clockLaneLowPower == $past(&pwdata[3:2], 2))
        else $error("config copy wrong");
    a_id_read: assert property (take && !pwrite && paddr == 12'h3C0 |=>
        prdata[7:0] == `DCP_ID_FIRST_VAL) else $error("identity byte wrong");
    a_pin_read: assert property (take && !pwrite && paddr == 12'h1BC |=>
        prdata[7:0] == {6'h00, $past(pinLevel[9:8])}) else $error("pin status wrong");
    c_cfg: cover property (take && pwrite && paddr == 12'h1A8);
    c_err: cover property (selftestError);
    c_clp: cover property (clockLaneLowPower);
endmodule // dcp_ctrl_regs_monitor
bind dcp_ctrl_regs dcp_ctrl_regs_monitor u_mon (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pinLevel(pinLevel), .selftestRun(selftestRun),
    .selftestError(selftestError), .laneCount(laneCount), .dataLaneLowPower(dataLaneLowPower),
    .clockLaneLowPower(clockLaneLowPower), .csiSoftReset(csiSoftReset));

//--- tb_top.sv
// Purpose: self-checking bench for dcp_ctrl_regs
// Assumes: answer comes with pready, no fixed wait
// Notes: reads queue their expected byte
`timescale 1ns/1ps
`include "dcp_defines.vh"
module tb_top;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rxVsync, rxDataEnable, rxPixel;
    logic vsyncActive, dataEnableActive, selftestRun, selftestError, internalTiming;
    logic dataLaneLowPower, clockLaneLowPower, continuousClock, csiSoftReset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] pinLevel, e, q[$];
    logic [23:0] rxVideo, genVideo;
    logic [2:0] laneCount, ln[4] = '{3'h4, 3'h4, 3'h2, 3'h1};
    logic [3:0] outputFormat;
    logic [1:0] inputFormat;
    logic [7:0] d, x, rw[5] = '{8'h66, 8'h68, 8'h6A, 8'h6B, 8'h6C};
    logic [7:0] ro[5] = '{8'h69, 8'h6E, 8'h6F, 8'hF0, 8'hF1};
    logic [7:0] rx[5] = '{8'h00, 8'h00, 8'h00, `DCP_ID_FIRST_VAL, `DCP_ID_SECOND_VAL};
    int n_fail, checks, seed = 24;
    dcp_ctrl_regs u_dut (.*);
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // ==========
    // helpers
    task cmp(input logic [15:0] g, input logic [15:0] v);
        checks++;
        if (g !== v)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, v);
        end
    endtask
    // e: bit9 check data, bit8 error expected, low byte data
    task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] v, input logic [9:0] x);
        int n = 0;
        @(posedge clk);
        q.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, v};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] i, input logic [7:0] v);
        xf(1'b1, {2'b00, i, 2'b00}, v, 10'h000);
    endtask
    task rd(input logic [7:0] i, input logic [7:0] v);
        xf(1'b0, {2'b00, i, 2'b00}, 8'h00, {2'b10, v});
    endtask
    task tally_and_finish;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk)
        if (pready === 1'b1)
        begin
            e = q.pop_front();
            cmp({pslverr, e[9] ? prdata[7:0] : 8'h00}, {e[8], e[9] ? e[7:0] : 8'h00});
        end
    initial
    begin
        #200000;
        n_fail++;
        tally_and_finish;
    end
    // ==========
    // tests
    initial
    begin
        {rst_n, psel, penable, pwrite, rxVsync, rxDataEnable, rxPixel} = 7'h00;
        {paddr, pwdata, pinLevel, rxVideo, genVideo} = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        cmp(laneCount, 3'h4);
        for (int i = 0; i < 12; i++)
            rd(i < 10 ? 8'h66 + i : 8'hE6 + i, i < 10 ? 8'h00 : rx[i - 7]);
        $display("done reset");
        foreach (rw[i])
        begin
            d = $random(seed);
            wr(rw[i], d);
            rd(rw[i], d);
        end
        for (int k = 0; k < 2; k++)
        begin
            d = $random(seed);
            x = $random(seed);
            wr(8'h66 + 6 * k, 8'h10);
            wr(8'h67 + 6 * k, d);
            wr(8'h66 + 6 * k, 8'h11);
            wr(8'h67 + 6 * k, x);
            wr(8'h66 + 6 * k, 8'h10);
            rd(8'h67 + 6 * k, d);
        end
        $display("done indirect");
        for (int c = 0; c < 4; c++)
        begin
            d = {2'b00, c[1:0], c[1], c[0], c[0], c[1]};
            wr(8'h6A, d);
            repeat (2) @(negedge clk);
            cmp({laneCount, dataLaneLowPower, clockLaneLowPower, continuousClock, csiSoftReset},
                {ln[c], d[3], d[3] & d[2], d[1], d[0]});
        end
        for (int f = 0; f < 10; f++)
        begin
            d = {f[3:0], f[1:0], 2'b00};
            wr(8'h6B, d);
            repeat (2) @(negedge clk);
            cmp({outputFormat, inputFormat}, d[7:2]);
        end
        $display("done config");
        @(posedge clk);
        rxVsync <= 1'b1;
        wr(8'h6B, 8'h03);
        repeat (2) @(negedge clk);
        cmp({vsyncActive, dataEnableActive}, 2'b01);
        wr(8'h6B, 8'h00);
        repeat (2) @(negedge clk);
        cmp({vsyncActive, dataEnableActive}, 2'b10);
        foreach (ro[i])
        begin
            d = $random(seed);
            wr(ro[i], d);
            rd(ro[i], rx[i]);
        end
        xf(1'b1, 12'h1C0, 8'h5A, 10'h100);
        xf(1'b0, 12'h1A9, 8'h00, 10'h300);
        @(posedge clk);
        pinLevel <= 10'($random(seed));
        @(posedge clk);
        rd(8'h6E, {pinLevel[7:5], 1'b0, pinLevel[3:0]});
        rd(8'h6F, {6'h00, pinLevel[9:8]});
        $display("done status");
        wr(8'h68, 8'h08);
        {rxPixel, rxDataEnable, rxVideo} <= {2'b11, 24'h000001};
        repeat (6) @(negedge clk);
        cmp({selftestRun, selftestError}, 2'b11);
        rd(8'h69, 8'h80);
        wr(8'h68, 8'h00);
        rxPixel <= 1'b0;
        rd(8'h69, 8'h00);
        genVideo <= 24'h000001;
        rxPixel <= 1'b1;
        wr(8'h68, 8'h08);
        repeat (6) @(negedge clk);
        cmp({selftestRun, selftestError}, 2'b10);
        @(posedge clk);
        rxPixel <= 1'b0;
        wr(8'h66, `DCP_TP_TIMING_LOC);
        wr(8'h67, 8'h04);
        repeat (2) @(negedge clk);
        cmp(internalTiming, 1'b1);
        $display("done selftest");
        tally_and_finish;
    end
endmodule // tb_top
